/* File: core/acd_pkg.sv */
// Package of shared constants, field layouts and bus carriers for the sample clock chain.
package acd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets within the slave window.
  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_OFFSET   = 8'h04;
  localparam logic [7:0] REG_GAIN     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_MASK     = 8'h10;
  localparam logic [7:0] REG_RESULT   = 8'h14;
  localparam logic [7:0] REG_POSITION = 8'h18;

  //////////////////////////////////////////////////////////////////////////////
  // Field layout of the first configuration register.
  localparam int CFG_W         = 7;
  localparam int PRESCALE_LSB  = 0;
  localparam int OSR_LSB       = 2;
  localparam int CLKSEL_BIT    = 5;
  localparam int TWO_WIRE_BIT  = 6;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [2:0] OSR_RESET      = 3'h3;
  localparam logic       CLKSEL_RESET   = 1'h0;
  localparam logic       TWO_WIRE_RESET = 1'h0;
  localparam logic [CFG_W-1:0] CFG_RESET =
    {TWO_WIRE_RESET, CLKSEL_RESET, OSR_RESET, PRESCALE_RESET};

  // Status and mask bit positions.
  localparam int STAT_W        = 2;
  localparam int STAT_READY    = 0;
  localparam int STAT_SATURATE = 1;

  // Correction words and their reset values.
  localparam int WORD_W = 24;
  localparam logic [WORD_W-1:0] OFFSET_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] GAIN_RESET   = 24'h000000;

  //////////////////////////////////////////////////////////////////////////////
  // Timing counts of the divider chain.
  localparam int PRE_W   = 4;
  localparam int DM_W    = 3;
  localparam int OSR_W   = 13;
  localparam logic [DM_W-1:0] DM_DIVISOR = 3'h4;
  localparam logic [1:0] READY_LOW_ANALOG_MODULATOR_CLOCK = 2'h2;

  // AHB-Lite encodings used by the slave.
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Bus carriers.
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } acd_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } acd_ahb_rsp_t;

  // Prescale code to divisor: 1, 2, 4 or 8.
  function automatic logic [PRE_W-1:0] acd_prescale_div(input logic [1:0] code);
    acd_prescale_div = 4'h1 << code;
  endfunction

  // Oversampling code to ratio: 32 up to 4096.
  function automatic logic [OSR_W-1:0] acd_osr_ratio(input logic [2:0] code);
    acd_osr_ratio = 13'h0020 << code;
  endfunction

endpackage

/* File: core/acd_divider.sv */
// Counting divider that turns an input tick stream into one output tick per modulus.
module acd_divider #(
  parameter int W = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [W-1:0] modulus,
  output logic tick_out,
  output logic [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } acd_div_state_t;

  acd_div_state_t st;
  acd_div_state_t next_st;

  // A count at or past the last step wraps, so a smaller modulus written on
  // the fly never leaves the counter stranded above it.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.count = '0;
    end else if (tick_in) begin
      if (st.count >= modulus - W'(1)) begin
        next_st.count = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + W'(1);
      end
    end
  end

  // Counters start from zero after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
  assign count = st.count;

endmodule

/* File: core/acd_corrector.sv */
// Offset and gain correction of one conversion result, with saturation.
module acd_corrector (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [23:0] raw,
  input wire logic [23:0] offset,
  input wire logic [23:0] gain,
  output logic [23:0] result,
  output logic saturated
);

  typedef struct packed {
    logic [23:0] result;
    logic        saturated;
  } acd_cor_state_t;

  acd_cor_state_t st;
  acd_cor_state_t next_st;
  logic signed [24:0] shifted;
  logic signed [48:0] product;
  logic signed [26:0] total;

  // Result = (raw + offset) * (1 + gain / 2^23), clipped to 24 bits.
  always_comb begin
    next_st = st;
    shifted = $signed({raw[23], raw}) + $signed({offset[23], offset});
    product = shifted * $signed(gain);
    total = $signed({{2{shifted[24]}}, shifted})
          + $signed({product[48], product[48:23]});
    if (load) begin
      if (total[26:23] != {4{total[26]}}) begin
        next_st.result = total[26] ? 24'h800000 : 24'h7FFFFF;
        next_st.saturated = 1'b1;
      end else begin
        next_st.result = total[23:0];
        next_st.saturated = 1'b0;
      end
    end
  end

  // Result register holds until the next conversion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result = st.result;
  assign saturated = st.saturated;

endmodule

/* File: core/acd_clock_chain.sv */
// Top of the sample clock chain: source select, dividers, data ready and registers.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.

//////////////////////////////////////////////////////////////////////////////
module acd_clock_chain (
  input wire logic hclk,
  input wire logic hresetn,
  input wire acd_pkg::acd_ahb_req_t bus_req,
  output acd_pkg::acd_ahb_rsp_t bus_rsp,
  input wire logic crystal_clock,
  input wire logic clock_input_pin,
  input wire logic serial_clock_pin,
  input wire logic [23:0] raw_result,
  output logic data_ready_output_n,
  output logic sample_strobe,
  output logic irq
);

  typedef struct packed {
    logic [2:0]                    sync1;
    logic [2:0]                    sync2;
    logic                          clk_prev;
    logic                          mclk_tick;
    logic [acd_pkg::CFG_W-1:0]     first_config_register;
    logic [acd_pkg::WORD_W-1:0]    offset_correction_word;
    logic [acd_pkg::WORD_W-1:0]    gain_correction_word;
    logic [acd_pkg::STAT_W-1:0]    status;
    logic [acd_pkg::STAT_W-1:0]    mask;
    logic                          wr_pend;
    logic [7:0]                    wr_addr;
    logic [1:0]                    analog_modulator_clock_dly;
    logic [1:0]                    low_cnt;
    logic                          load_d;
    logic                          clear_div;
    logic                          drdy_n;
    logic                          sample_strobe;
    logic                          irq;
    acd_pkg::acd_ahb_rsp_t         rsp;
  } acd_state_t;

  acd_state_t st;
  acd_state_t next_st;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded configuration and chain wires.
  logic [1:0] prescale_code;
  logic [2:0] oversample_code;
  logic external_clock_select;
  logic two_wire_mode;
  logic [acd_pkg::PRE_W-1:0] prescale_div;
  logic [acd_pkg::OSR_W-1:0] oversample_ratio;
  logic analog_modulator_clock;
  logic digital_sample_clock;
  logic output_rate_clock;
  logic [acd_pkg::PRE_W-1:0] pre_count;
  logic [acd_pkg::DM_W-1:0] dm_count;
  logic [acd_pkg::OSR_W-1:0] position;
  logic [23:0] corrected;
  logic corrected_sat;
  logic selected_clock;
  logic accept;
  logic [7:0] rd_addr;
  logic [31:0] rd_value;

  // Configuration fields as seen by the dividers.
  assign prescale_code = st.first_config_register[acd_pkg::PRESCALE_LSB +: 2];
  assign oversample_code = st.first_config_register[acd_pkg::OSR_LSB +: 3];
  assign external_clock_select = st.first_config_register[acd_pkg::CLKSEL_BIT];
  assign two_wire_mode = st.first_config_register[acd_pkg::TWO_WIRE_BIT];
  assign prescale_div = acd_pkg::acd_prescale_div(prescale_code);
  assign oversample_ratio = acd_pkg::acd_osr_ratio(oversample_code);

  //////////////////////////////////////////////////////////////////////////////
  // Divider chain: prescaler, fixed divide by four, oversampling divider.
  acd_divider #(
    .W(acd_pkg::PRE_W)
  ) u_prescale (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(st.clear_div),
    .tick_in(st.mclk_tick),
    .modulus(prescale_div),
    .tick_out(analog_modulator_clock),
    .count(pre_count)
  );

  // The fixed divide by four forms the sampling rate.
  acd_divider #(
    .W(acd_pkg::DM_W)
  ) u_sample (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(st.clear_div),
    .tick_in(analog_modulator_clock),
    .modulus(acd_pkg::DM_DIVISOR),
    .tick_out(digital_sample_clock),
    .count(dm_count)
  );

  // The oversampling divider counts samples into one output period.
  acd_divider #(
    .W(acd_pkg::OSR_W)
  ) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(st.clear_div),
    .tick_in(digital_sample_clock),
    .modulus(oversample_ratio),
    .tick_out(output_rate_clock),
    .count(position)
  );

  // Correction is loaded on each output tick, in step with data ready.
  acd_corrector u_correct (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(output_rate_clock),
    .raw(raw_result),
    .offset(st.offset_correction_word),
    .gain(st.gain_correction_word),
    .result(corrected),
    .saturated(corrected_sat)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Source choice reads only the second synchroniser stage.
  always_comb begin
    if (two_wire_mode) begin
      selected_clock = st.sync2[0];
    end else if (external_clock_select) begin
      selected_clock = st.sync2[1];
    end else begin
      selected_clock = st.sync2[2];
    end
  end

  // Address phase qualification and the register read mux.
  assign accept = bus_req.hsel & bus_req.hready & bus_req.htrans[1];
  assign rd_addr = bus_req.haddr[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    rd_value = 32'h00000000;

    // Clock pins pass two flip-flops; a rising edge on the chosen one is one
    // main clock tick. Pin clocks must stay below half the bus clock rate.
    next_st.sync1 = {crystal_clock, clock_input_pin, serial_clock_pin};
    next_st.sync2 = st.sync1;
    next_st.clk_prev = selected_clock;
    next_st.mclk_tick = selected_clock & ~st.clk_prev;
    next_st.clear_div = 1'b0;

    // One strobe per sampling period marks the new sample and modulator word.
    next_st.sample_strobe = digital_sample_clock;

    // The modulator tick is delayed by two cycles to match the latency from
    // the modulator tick through two dividers to the output tick, so the low time is exact.
    next_st.analog_modulator_clock_dly = {st.analog_modulator_clock_dly[0], analog_modulator_clock};

    // Data ready falls on each output tick and rises after two modulator
    // periods, which is half a sampling period.
    if (output_rate_clock) begin
      next_st.drdy_n = 1'b0;
      next_st.low_cnt = acd_pkg::READY_LOW_ANALOG_MODULATOR_CLOCK;
    end else if (!st.drdy_n && st.analog_modulator_clock_dly[1]) begin
      if (st.low_cnt == 2'h1) begin
        next_st.drdy_n = 1'b1;
        next_st.low_cnt = 2'h0;
      end else begin
        next_st.low_cnt = st.low_cnt - 2'h1;
      end
    end
    next_st.load_d = output_rate_clock;

    // Data phase of a write lands here; only whole-word writes take effect.
    if (st.wr_pend) begin
      case (st.wr_addr)
        acd_pkg::REG_CONFIG: begin
          next_st.first_config_register = bus_req.hwdata[acd_pkg::CFG_W-1:0];
          next_st.clear_div = 1'b1;
          next_st.drdy_n = 1'b1;
          next_st.low_cnt = 2'h0;
        end
        acd_pkg::REG_OFFSET: begin
          next_st.offset_correction_word = bus_req.hwdata[acd_pkg::WORD_W-1:0];
        end
        acd_pkg::REG_GAIN: begin
          next_st.gain_correction_word = bus_req.hwdata[acd_pkg::WORD_W-1:0];
        end
        acd_pkg::REG_MASK: begin
          next_st.mask = bus_req.hwdata[acd_pkg::STAT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Address phase: the read value is prepared now so hrdata is a register
    // in the data phase; reading after a write sees the new value.
    next_st.wr_pend = accept & bus_req.hwrite & (bus_req.hsize == acd_pkg::HSIZE_WORD);
    next_st.wr_addr = rd_addr;
    if (accept && !bus_req.hwrite) begin
      case (rd_addr)
        acd_pkg::REG_CONFIG: begin
          rd_value = {25'h0000000, next_st.first_config_register};
        end
        acd_pkg::REG_OFFSET: begin
          rd_value = {8'h00, next_st.offset_correction_word};
        end
        acd_pkg::REG_GAIN: begin
          rd_value = {8'h00, next_st.gain_correction_word};
        end
        acd_pkg::REG_STATUS: begin
          rd_value = {30'h00000000, st.status};
          next_st.status = '0;
        end
        acd_pkg::REG_MASK: begin
          rd_value = {30'h00000000, next_st.mask};
        end
        acd_pkg::REG_RESULT: begin
          rd_value = {8'h00, corrected};
        end
        acd_pkg::REG_POSITION: begin
          rd_value = {19'h00000, position};
        end
        default: begin
          rd_value = 32'h00000000;
        end
      endcase
      next_st.rsp.hrdata = rd_value;
    end
    next_st.rsp.hreadyout = 1'b1;
    next_st.rsp.hresp = acd_pkg::HRESP_OKAY;

    // Hardware events are applied after the read clear, so a set wins.
    if (output_rate_clock) begin
      next_st.status[acd_pkg::STAT_READY] = 1'b1;
    end
    if (st.load_d && corrected_sat) begin
      next_st.status[acd_pkg::STAT_SATURATE] = 1'b1;
    end

    // Interrupt is a level while any unmasked status bit stands.
    next_st.irq = |(next_st.status & next_st.mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the chain idle with default configuration.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.first_config_register <= acd_pkg::CFG_RESET;
      st.offset_correction_word <= acd_pkg::OFFSET_RESET;
      st.gain_correction_word <= acd_pkg::GAIN_RESET;
      st.drdy_n <= 1'b1;
      st.rsp.hreadyout <= 1'b1;
      st.rsp.hresp <= acd_pkg::HRESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a flip-flop of the state.
  assign bus_rsp = st.rsp;
  assign data_ready_output_n = st.drdy_n;
  assign sample_strobe = st.sample_strobe;
  assign irq = st.irq;

endmodule

/* File: verif/acd_clock_src.sv */
// Clock source model for the three clock pins of the chain.
module acd_clock_src (
  input wire logic [2:0] run,
  output logic crystal_clock,
  output logic clock_input_pin,
  output logic serial_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each pin toggles every 50 ns while run; a stopped source rests low, as a dead crystal does.
  // The 3 ns offset keeps pin edges away from the bench clock edges.
  initial begin
    {crystal_clock, clock_input_pin, serial_clock_pin} = 3'h0;
    #3;
    forever begin
      #50;
      crystal_clock = run[0] & ~crystal_clock;
      clock_input_pin = run[1] & ~clock_input_pin;
      serial_clock_pin = run[2] & ~serial_clock_pin;
    end
  end
endmodule

/* File: verif/acd_clock_chain_assertions.sv */
// Concurrent checks on the ports of the sample clock chain.
module acd_clock_chain_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire acd_pkg::acd_ahb_req_t bus_req,
  input wire acd_pkg::acd_ahb_rsp_t bus_rsp,
  input wire logic crystal_clock,
  input wire logic clock_input_pin,
  input wire logic serial_clock_pin,
  input wire logic [23:0] raw_result,
  input wire logic data_ready_output_n,
  input wire logic sample_strobe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  int per;
  int low_len;
  int strobes;
  logic fresh;
  logic armed;
  logic cut;
  logic cfg_wr;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A CONFIG write restarts the chain, so counts that span one are not judged.
  assign cfg_wr = bus_req.hsel && bus_req.hready && bus_req.htrans[1] && bus_req.hwrite
    && bus_req.haddr[7:0] == acd_pkg::REG_CONFIG;

  // Measures strobe spacing, pulse width and strobes per output period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 0;
      per <= 0;
      low_len <= 0;
      strobes <= 0;
      fresh <= 1'b1;
      armed <= 1'b0;
      cut <= 1'b0;
    end else begin
      gap <= sample_strobe ? 1 : gap + 1;
      per <= sample_strobe ? gap : per;
      low_len <= data_ready_output_n ? 0 : low_len + 1;
      cut <= !data_ready_output_n && (cut || cfg_wr);
      strobes <= $fell(data_ready_output_n) ? 0 : strobes + (sample_strobe ? 1 : 0);
      fresh <= fresh && !cfg_wr && !$fell(data_ready_output_n);
      armed <= !cfg_wr && (armed || $fell(data_ready_output_n));
    end
  end

  ////////////////////////////////////////
  sequence s_fall;
    $fell(data_ready_output_n);
  endsequence
  sequence s_low;
    !data_ready_output_n [*2];
  endsequence

  chk_bus_okay: assert property (bus_rsp.hreadyout && bus_rsp.hresp == acd_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  chk_reset_idle: assert property ($rose(hresetn) |->
    data_ready_output_n && !sample_strobe && !irq)
    else $error("outputs not idle after reset");
  chk_strobe_single: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("sample strobe too long or too close");
  chk_pulse_shape: assert property (s_fall |-> s_low ##[1:298] data_ready_output_n)
    else $error("data ready pulse malformed");
  chk_pulse_width: assert property ($rose(data_ready_output_n) && !cut |->
    2 * low_len == per)
    else $error("data ready low time not half a sampling period");
  chk_first_ratio: assert property ($fell(data_ready_output_n) && fresh |->
    strobes == (32 << acd_pkg::OSR_RESET))
    else $error("first result not after default ratio");
  chk_ratio_code: assert property ($fell(data_ready_output_n) && armed |->
    $onehot(strobes) && strobes >= 32 && strobes <= 4096)
    else $error("strobes per result not a legal ratio");
  chk_ready_source: assert property (s_fall |->
    $past(sample_strobe) || $past(sample_strobe, 2))
    else $error("data ready not tied to a sample");
endmodule

/* File: verif/acd_clock_chain_bench.sv */
// Self-checking bench of the sample clock chain: registers, sources and rates.
module acd_clock_chain_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [23:0] raw_result = 24'h000000;
  logic [2:0] run = 3'h7;
  logic [31:0] rd;
  logic crystal_clock;
  logic clock_input_pin;
  logic serial_clock_pin;
  logic data_ready_output_n;
  logic sample_strobe;
  logic irq;
  acd_pkg::acd_ahb_req_t bus_req;
  acd_pkg::acd_ahb_rsp_t bus_rsp;
  int failures = 0;
  int total_checks = 0;
  int strobes = 0;

  // Only whole-word transfers are made, so hsize is fixed.
  assign bus_req = {hsel, haddr, htrans, hwrite, acd_pkg::HSIZE_WORD, hwdata, bus_rsp.hreadyout};

  // Clock of 40 MHz and a running count of sampling strobes.
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) strobes <= strobes + (sample_strobe === 1'b1 ? 1 : 0);

  acd_clock_chain i_acd_clock_chain (.hclk(hclk), .hresetn(hresetn), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .crystal_clock(crystal_clock), .clock_input_pin(clock_input_pin),
    .serial_clock_pin(serial_clock_pin), .raw_result(raw_result),
    .data_ready_output_n(data_ready_output_n), .sample_strobe(sample_strobe), .irq(irq));
  acd_clock_src i_acd_clock_src (.run(run), .crystal_clock(crystal_clock),
    .clock_input_pin(clock_input_pin), .serial_clock_pin(serial_clock_pin));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; read data lands in rd at the end of the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (bus_rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (bus_rsp.hreadyout !== 1'b1);
    rd = bus_rsp.hrdata;
  endtask

  // Waits until data ready is sampled at lvl, giving up after lim cycles.
  task automatic wait_dr(input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (data_ready_output_n !== lvl && n < lim);
  endtask

  task automatic t_reset();
    int n;
    bus(1'b0, acd_pkg::REG_CONFIG, 32'h0);
    check("config reset", rd, {25'h0, acd_pkg::CFG_RESET});
    bus(1'b0, acd_pkg::REG_OFFSET, 32'h0);
    check("offset reset", rd, {8'h00, acd_pkg::OFFSET_RESET});
    bus(1'b0, acd_pkg::REG_GAIN, 32'h0);
    check("gain reset", rd, {8'h00, acd_pkg::GAIN_RESET});
    bus(1'b1, 8'h1C, 32'h5A5A5A5A);
    bus(1'b0, 8'h1C, 32'h0);
    check("unmapped", rd, 32'h0);
    wait_dr(1'b0, 9000, n);
    check("first strobes", strobes, 256);
    $display("Test reset done");
  endtask

  task automatic t_correct(input logic [23:0] raw, off, gain, input logic [1:0] msk,
      input logic [23:0] res, input logic [1:0] st);
    int n;
    raw_result <= raw;
    bus(1'b1, acd_pkg::REG_OFFSET, {8'hFF, off});
    bus(1'b0, acd_pkg::REG_OFFSET, 32'h0);
    check("offset word", rd, {8'h00, off});
    bus(1'b1, acd_pkg::REG_GAIN, {8'hFF, gain});
    bus(1'b0, acd_pkg::REG_GAIN, 32'h0);
    check("gain word", rd, {8'h00, gain});
    bus(1'b1, acd_pkg::REG_MASK, {30'h0, msk});
    bus(1'b0, acd_pkg::REG_MASK, 32'h0);
    check("mask word", rd, {30'h0, msk});
    bus(1'b0, acd_pkg::REG_STATUS, 32'h0);
    wait_dr(1'b0, 9000, n);
    repeat (3) @(posedge hclk);
    check("irq raised", {31'h0, irq}, {31'h0, |(st & msk)});
    bus(1'b0, acd_pkg::REG_RESULT, 32'h0);
    check("result", rd, {8'h00, res});
    bus(1'b0, acd_pkg::REG_STATUS, 32'h0);
    check("status", rd, {30'h0, st});
    bus(1'b0, acd_pkg::REG_STATUS, 32'h0);
    check("status cleared", rd, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("Test correction done");
  endtask

  // Pin clocks run at 4 hclk cycles, so every expected figure scales from that.
  task automatic t_rate(input logic [1:0] pre, input logic [2:0] code);
    int n, lo, hi, s0;
    bus(1'b1, acd_pkg::REG_CONFIG, {27'h0, code, pre});
    wait_dr(1'b0, 20000, n);
    s0 = strobes;
    wait_dr(1'b1, 300, lo);
    wait_dr(1'b0, 20000, hi);
    check("low width", lo, 8 << pre);
    check("period", lo + hi, (16 << pre) * (32 << code));
    check("strobes per result", strobes - s0, 32 << code);
    $display("Test rate done");
  endtask

  task automatic t_src(input logic [2:0] pins, input logic [1:0] mode, input logic exp);
    int n;
    run <= pins;
    bus(1'b1, acd_pkg::REG_CONFIG, {25'h0, mode, 5'h00});
    wait_dr(1'b0, 1200, n);
    check("source result", {31'h0, data_ready_output_n}, {31'h0, !exp});
    // Either the rate counter has just wrapped or it never saw a sample.
    bus(1'b0, acd_pkg::REG_POSITION, 32'h0);
    check("position", rd, 32'h0);
    $display("Test source done");
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The tests need about 39000 cycles; the limit allows well over that.
  initial begin
    #2500000;
    failures++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_correct(24'h000100, 24'h000010, 24'h400000, 2'h3, 24'h000198, 2'h1);
    t_correct(24'h000100, 24'h7FFFFF, 24'h000000, 2'h0, 24'h7FFFFF, 2'h3);
    for (int p = 1; p < 4; p++) t_rate(p[1:0], 3'h0);
    for (int c = 0; c < 3; c++) t_rate(2'h0, c[2:0]);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, acd_pkg::REG_CONFIG, {27'h0, c[2:0], c[1:0]});
      bus(1'b0, acd_pkg::REG_CONFIG, 32'h0);
      check("ratio code", rd, {27'h0, c[2:0], c[1:0]});
    end
    t_src(3'h2, 2'h1, 1'b1);
    t_src(3'h5, 2'h1, 1'b0);
    t_src(3'h4, 2'h2, 1'b1);
    t_src(3'h3, 2'h3, 1'b0);
    t_src(3'h1, 2'h0, 1'b1);
    t_src(3'h6, 2'h0, 1'b0);
    end_sim();
  end
endmodule

bind acd_clock_chain acd_clock_chain_assertions i_acd_clock_chain_assertions (.hclk(hclk),
  .hresetn(hresetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .crystal_clock(crystal_clock),
  .clock_input_pin(clock_input_pin), .serial_clock_pin(serial_clock_pin),
  .raw_result(raw_result), .data_ready_output_n(data_ready_output_n),
  .sample_strobe(sample_strobe), .irq(irq));
